// >>> rtl/fpp_pkg.sv
// Constants, types and pin bundles for the fast parallel port.
// Assumes one 40 MHz clock and a synchronous active-high reset everywhere.
package fpp_pkg;

   localparam int unsigned CLOCK_HZ = 40_000_000;
   localparam int unsigned IFACE_HZ = 20_000_000;
   // Half period of the interface clock in system cycles, never below one.
   localparam int unsigned IFACE_HALF_CYCLES =
      (CLOCK_HZ / (2 * IFACE_HZ)) < 1 ? 1 : (CLOCK_HZ / (2 * IFACE_HZ));

   localparam int unsigned PACKET_MAX_BYTES = 512;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned LEN_W = 10;

   localparam logic CMD_SEL_COMMAND = 1'b0;
   localparam logic CMD_SEL_DATA = 1'b1;
   localparam logic [LEN_W-1:0] LEN_MAX = 10'h200;

   typedef enum logic [0:0] {
      FPP_IDLE = 1'b0,
      FPP_XFER = 1'b1
   } fpp_state_t;

   typedef struct packed {
      logic read_dir;
      logic is_data;
      logic wide;
      logic addr_en;
      logic [LEN_W-1:0] len_bytes;
      logic [ADDR_W-1:0] start_addr;
   } fpp_req_t;

   typedef struct packed {
      logic [7:0] b_out;
      logic [7:0] b_oe;
      logic [7:0] c_out;
      logic [7:0] c_oe;
      logic [7:0] d_out;
      logic [7:0] d_oe;
      logic spi_slave_select_1;
   } fpp_gpio_t;

   typedef struct packed {
      logic cmd_data_sel;
      logic read_strobe;
      logic read_strobe_lo;
      logic write_strobe;
      logic write_strobe_lo;
      logic addr_valid_out;
      logic [DATA_W-1:0] data_out;
      logic [DATA_W-1:0] data_oe;
      logic [ADDR_W-1:0] addr_out;
      logic [ADDR_W-1:0] addr_oe;
   } fpp_pins_t;

   localparam fpp_pins_t PINS_RESET = '{
      cmd_data_sel: CMD_SEL_COMMAND, read_strobe: 1'b0, read_strobe_lo: 1'b1,
      write_strobe: 1'b0, write_strobe_lo: 1'b1, addr_valid_out: 1'b0,
      data_out: 16'h0000, data_oe: 16'h0000, addr_out: 9'h000, addr_oe: 9'h000};

endpackage

// >>> rtl/fpp_fifo.sv
// Synchronous FIFO with valid/ready on both sides and an occupancy count.
// Assumes writer and reader share the clock; first word falls through.
`timescale 1ns/10ps
module fpp_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] count
);
   localparam int unsigned PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [PW:0] next_count;
   logic push, pop;

   assign in_ready = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
      next_count = count;
      if (push && !pop) begin
         next_count = (PW+1)'(count + 1'b1);
      end else if (pop && !push) begin
         next_count = (PW+1)'(count - 1'b1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // Storage has no reset; only words already counted are ever read.
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule // fpp_fifo

// >>> rtl/fpp_clk_div.sv
// Divider making the interface clock driven out to the target.
// Assumes the system clock is the only clock; the output is a plain register.
`timescale 1ns/10ps
module fpp_clk_div #(
   parameter int unsigned HALF_CYCLES = 1
) (
   input wire logic clock,
   input wire logic rst,
   output logic clk_level,
   output logic fall_tick,
   output logic rise_tick
);
   localparam int unsigned CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
   logic [CW-1:0] cnt, next_cnt;
   logic next_level, wrap;

   assign wrap = (cnt == CW'(HALF_CYCLES - 1));
   // Ticks mark the cycle whose closing edge moves the output clock.
   assign fall_tick = wrap && clk_level;
   assign rise_tick = wrap && !clk_level;

   always_comb begin
      next_cnt = wrap ? '0 : CW'(cnt + 1'b1);
      next_level = wrap ? !clk_level : clk_level;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cnt <= '0;
         clk_level <= 1'b0;
      end else begin
         cnt <= next_cnt;
         clk_level <= next_level;
      end
   end
endmodule // fpp_clk_div

// >>> rtl/fpp_port.sv
// Fast parallel port engine: moves one packet between the FIFO and the target.
// Assumes the target samples every port output on the rising interface clock edge
// and, during reads, presents data on that edge for capture at the next falling one.
`timescale 1ns/10ps
module fpp_port #(
   parameter int unsigned DEPTH = fpp_pkg::FIFO_DEPTH,
   parameter int unsigned HALF_CYCLES = fpp_pkg::IFACE_HALF_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic req_valid,
   output logic req_ready,
   input wire fpp_pkg::fpp_req_t req,
   output logic done,
   output logic refused,
   output logic busy,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [fpp_pkg::DATA_W-1:0] wr_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [fpp_pkg::DATA_W-1:0] rd_data,
   input wire fpp_pkg::fpp_gpio_t gpio,
   output logic interface_clk_out,
   output fpp_pkg::fpp_pins_t pins,
   input wire logic [fpp_pkg::DATA_W-1:0] port_data_bus_in
);
   localparam int unsigned CNTW = $clog2(DEPTH) + 1;

   fpp_pkg::fpp_state_t state, next_state;
   fpp_pkg::fpp_pins_t next_pins;
   logic read_dir, is_data, wide, addr_en;
   logic next_read_dir, next_is_data, next_wide, next_addr_en;
   logic [fpp_pkg::LEN_W-1:0] left, next_left;
   logic [fpp_pkg::ADDR_W-1:0] addr, next_addr;
   logic next_done, next_refused;
   logic fall_tick, rise_tick;
   logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
   logic [fpp_pkg::DATA_W-1:0] f_in_data, f_out_data;
   logic [CNTW-1:0] f_count;
   logic capture_now, space_ok, move, req_bad;
   logic [fpp_pkg::LEN_W-1:0] req_elems;
   logic [CNTW:0] fill_after;

   fpp_clk_div #(.HALF_CYCLES(HALF_CYCLES)) u_div (
      .clock(clock),
      .rst(rst),
      .clk_level(interface_clk_out),
      .fall_tick(fall_tick),
      .rise_tick(rise_tick)
   );

   fpp_fifo #(.WIDTH(fpp_pkg::DATA_W), .DEPTH(DEPTH)) u_fifo (
      .clock(clock),
      .rst(rst),
      .in_valid(f_in_valid),
      .in_ready(f_in_ready),
      .in_data(f_in_data),
      .out_valid(f_out_valid),
      .out_ready(f_out_ready),
      .out_data(f_out_data),
      .count(f_count)
   );

   // A read element is taken at the falling edge that ends its strobe period.
   assign capture_now = fall_tick && pins.read_strobe;
   // The FIFO faces the host writer or the bus capture, by the latched direction.
   // Host data left from the other direction is the host's to drain first.
   assign f_in_valid = read_dir ? capture_now : wr_valid;
   assign f_in_data = read_dir ? (wide ? port_data_bus_in : {8'h00, port_data_bus_in[7:0]})
                               : wr_data;
   assign wr_ready = !read_dir && f_in_ready;
   assign rd_valid = read_dir && f_out_valid;
   assign rd_data = f_out_data;
   assign f_out_ready = read_dir ? rd_ready : (move && !read_dir);

   // Back-pressure: a new read strobe needs room for it and any capture now in flight.
   assign fill_after = (CNTW+1)'(f_count) + (CNTW+1)'(capture_now);
   assign space_ok = (fill_after < (CNTW+1)'(DEPTH));
   assign move = fall_tick && (state == fpp_pkg::FPP_XFER) && (left != '0) &&
                 (read_dir ? space_ok : f_out_valid);

   assign req_ready = (state == fpp_pkg::FPP_IDLE);
   assign busy = (state == fpp_pkg::FPP_XFER);
   assign req_elems = req.wide ? {1'b0, req.len_bytes[fpp_pkg::LEN_W-1:1]} : req.len_bytes;
   assign req_bad = (req.len_bytes == '0) || (req.len_bytes > fpp_pkg::LEN_MAX) ||
                    (req.wide && req.len_bytes[0]);

   always_comb begin
      next_state = state;
      next_read_dir = read_dir;
      next_is_data = is_data;
      next_wide = wide;
      next_addr_en = addr_en;
      next_left = left;
      next_addr = addr;
      next_done = 1'b0;
      next_refused = 1'b0;
      next_pins = pins;
      unique case (state)
         fpp_pkg::FPP_IDLE: begin
            if (req_valid) begin
               if (req_bad) begin
                  next_refused = 1'b1;
               end else begin
                  next_state = fpp_pkg::FPP_XFER;
                  next_read_dir = req.read_dir;
                  next_is_data = req.is_data;
                  next_wide = req.wide;
                  next_addr_en = req.addr_en;
                  next_left = req_elems;
                  next_addr = req.start_addr;
               end
            end
         end
         fpp_pkg::FPP_XFER: begin
            if (fall_tick) begin
               next_pins.cmd_data_sel = is_data ? fpp_pkg::CMD_SEL_DATA
                                                : fpp_pkg::CMD_SEL_COMMAND;
               next_pins.addr_valid_out = addr_en;
               next_pins.read_strobe = move && read_dir;
               next_pins.read_strobe_lo = !(move && read_dir);
               next_pins.write_strobe = move && !read_dir;
               next_pins.write_strobe_lo = !(move && !read_dir);
               if (move) begin
                  next_pins.addr_out = addr;
                  next_addr = fpp_pkg::ADDR_W'(addr + 1'b1);
                  next_left = fpp_pkg::LEN_W'(left - 1'b1);
                  if (!read_dir) begin
                     next_pins.data_out[7:0] = f_out_data[7:0];
                     if (wide) begin
                        next_pins.data_out[15:8] = f_out_data[15:8];
                     end
                  end
               end else if (left == '0) begin
                  // Last strobe period has closed; any read capture happens this edge.
                  next_pins.addr_valid_out = 1'b0;
                  next_state = fpp_pkg::FPP_IDLE;
                  next_done = 1'b1;
               end
            end
         end
      endcase
      // Lanes not claimed by the port carry the general ports, cycle by cycle.
      if (next_state == fpp_pkg::FPP_XFER) begin
         next_pins.data_oe[7:0] = next_read_dir ? 8'h00 : 8'hFF;
      end else begin
         next_pins.data_out[7:0] = gpio.b_out;
         next_pins.data_oe[7:0] = gpio.b_oe;
      end
      if (next_state == fpp_pkg::FPP_XFER && next_wide) begin
         next_pins.data_oe[15:8] = next_read_dir ? 8'h00 : 8'hFF;
      end else begin
         next_pins.data_out[15:8] = gpio.d_out;
         next_pins.data_oe[15:8] = gpio.d_oe;
      end
      if (next_state == fpp_pkg::FPP_XFER && next_addr_en) begin
         next_pins.addr_oe = 9'h1FF;
      end else begin
         next_pins.addr_out = {gpio.spi_slave_select_1, gpio.c_out};
         next_pins.addr_oe = {1'b1, gpio.c_oe};
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= fpp_pkg::FPP_IDLE;
         read_dir <= 1'b0;
         is_data <= fpp_pkg::CMD_SEL_COMMAND;
         wide <= 1'b0;
         addr_en <= 1'b0;
         left <= '0;
         addr <= '0;
         done <= 1'b0;
         refused <= 1'b0;
         pins <= fpp_pkg::PINS_RESET;
      end else begin
         state <= next_state;
         read_dir <= next_read_dir;
         is_data <= next_is_data;
         wide <= next_wide;
         addr_en <= next_addr_en;
         left <= next_left;
         addr <= next_addr;
         done <= next_done;
         refused <= next_refused;
         pins <= next_pins;
      end
   end

   // Checking helpers: strobes issued in this packet and its start address.
   logic [fpp_pkg::LEN_W:0] strobes_sent, next_strobes_sent;
   logic [fpp_pkg::ADDR_W-1:0] start_addr_seen, next_start_addr_seen;

   always_comb begin
      next_strobes_sent = strobes_sent;
      next_start_addr_seen = start_addr_seen;
      if (req_valid && req_ready && !req_bad) begin
         next_strobes_sent = '0;
         next_start_addr_seen = req.start_addr;
      end else if (move) begin
         next_strobes_sent = (fpp_pkg::LEN_W+1)'(strobes_sent + 1'b1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         strobes_sent <= '0;
         start_addr_seen <= '0;
      end else begin
         strobes_sent <= next_strobes_sent;
         start_addr_seen <= next_start_addr_seen;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   read_strobe_pair_a: assert property (
      pins.read_strobe == !pins.read_strobe_lo)
      else $error("read strobes are not complementary");

   write_strobe_pair_a: assert property (
      pins.write_strobe == !pins.write_strobe_lo)
      else $error("write strobes are not complementary");

   strobe_exclusive_a: assert property (
      !(pins.read_strobe && pins.write_strobe) && (!pins.read_strobe || read_dir))
      else $error("read strobe without a read transfer");

   cmd_select_a: assert property (
      (pins.read_strobe || pins.write_strobe) |-> pins.cmd_data_sel == is_data)
      else $error("command/data select disagrees with the transfer kind");

   edge_aligned_a: assert property (
      ($changed(pins.read_strobe) || $changed(pins.write_strobe) ||
       $changed(pins.cmd_data_sel)) |-> $past(fall_tick) && !interface_clk_out)
      else $error("port control changed away from a falling interface edge");

   addr_valid_a: assert property (
      (pins.read_strobe || pins.write_strobe) && addr_en |-> pins.addr_valid_out)
      else $error("address valid missing during an addressed transfer");

   addr_follows_a: assert property (
      (pins.write_strobe || pins.read_strobe) && addr_en |->
         pins.addr_out == fpp_pkg::ADDR_W'(start_addr_seen + strobes_sent - 1'b1))
      else $error("element address does not match the element count");

   packet_cap_a: assert property (
      busy |-> (wide ? {strobes_sent, 1'b0} : {1'b0, strobes_sent}) <=
               (fpp_pkg::LEN_W+2)'(fpp_pkg::PACKET_MAX_BYTES))
      else $error("packet exceeded its byte limit");

   narrow_lanes_a: assert property (
      busy && !wide && $past(busy) |-> pins.data_oe[15:8] == $past(gpio.d_oe))
      else $error("upper byte lanes taken in narrow mode");

   addr_pins_a: assert property (
      busy && addr_en ##1 busy |-> pins.addr_oe == 9'h1FF)
      else $error("address pins not driven during an addressed transfer");

   refuse_pulse_a: assert property (
      req_valid && req_ready && req_bad |=> refused && !busy ##1 !refused)
      else $error("bad packet length was not refused for exactly one cycle");

   // While a packet owns the low lanes, they point toward the target for writes and away from it for reads.
   low_lanes_dir_a: assert property (
      busy |-> pins.data_oe[7:0] == (read_dir ? 8'h00 : 8'hFF))
      else $error("low data lanes point the wrong way during a transfer");

   wide_lanes_dir_a: assert property (
      busy && wide |-> pins.data_oe[15:8] == (read_dir ? 8'h00 : 8'hFF))
      else $error("upper data lanes point the wrong way in wide mode");

   idle_strobes_a: assert property (
      !busy |-> !pins.read_strobe && !pins.write_strobe)
      else $error("strobe active outside a transfer");

   strobe_hold_a: assert property (
      $rose(pins.read_strobe) || $rose(pins.write_strobe) |=>
         pins.read_strobe || pins.write_strobe)
      else $error("strobe shorter than one interface period");

   done_ends_busy_a: assert property (
      $fell(busy) |-> done)
      else $error("transfer ended without a done pulse");

   done_pulse_a: assert property (
      done |=> !done)
      else $error("done pulse longer than one cycle");

   addr_hold_a: assert property (
      busy && addr_en && $changed(pins.addr_out) |-> $past(fall_tick))
      else $error("element address moved between interface edges");

   // The target may sample write data anywhere in the period, so it must not move early.
   write_data_hold_a: assert property (
      busy && !read_dir && !$past(fall_tick) |-> $stable(pins.data_out[7:0]))
      else $error("write data moved between interface edges");

   read_room_a: assert property (
      capture_now |-> f_in_ready)
      else $error("read capture would overrun the FIFO");

endmodule // fpp_port

// >>> bench/fpp_target_model.sv
// Target logic on the peripheral board, facing the fast parallel port pins.
// Assumes the bench merges the returned lane values with the lanes the device drives.
`timescale 1ns/10ps
module fpp_target_model (
   input wire logic interface_clk_out,
   input wire fpp_pkg::fpp_pins_t pins,
   output logic [15:0] tgt_data,
   output int bad
);
   logic [26:0] wr_log[$];
   logic [8:0] rd_log[$];

   initial begin
      tgt_data = 16'h0000;
      bad = 0;
   end

   // Lanes not driven for a read keep changing, so stale data never passes for a capture.
   always @(interface_clk_out) begin
      if (interface_clk_out) begin
         if (pins.read_strobe_lo !== ~pins.read_strobe) bad <= bad + 1;
         if (pins.write_strobe_lo !== ~pins.write_strobe) bad <= bad + 1;
         if (pins.write_strobe === 1'b1) begin
            wr_log.push_back({pins.addr_valid_out, pins.cmd_data_sel, pins.addr_out,
                              pins.data_out});
         end
         if (pins.read_strobe === 1'b1) begin
            rd_log.push_back(pins.addr_out);
            tgt_data <= {pins.addr_out[7:0] ^ 8'hA5, pins.addr_out[7:0]};
         end else begin
            tgt_data <= ~tgt_data;
         end
      end else begin
         tgt_data <= ~tgt_data;
      end
   end
endmodule // fpp_target_model

// >>> bench/usb_module_fast_parallel_port_tb.sv
// Self-checking bench for the fast parallel port engine.
// Assumes the target model beside it and a 40 MHz system clock.
`timescale 1ns/10ps
module usb_module_fast_parallel_port_tb;
   logic clock, rst, req_valid, wr_valid, rd_ready;
   logic req_ready, done, refused, busy, wr_ready, rd_valid, interface_clk_out;
   logic [15:0] wr_data, rd_data, tgt_data, bus_in;
   fpp_pkg::fpp_req_t req;
   fpp_pkg::fpp_gpio_t gpio;
   fpp_pkg::fpp_pins_t pins;
   int fails, checked, bad;

   assign bus_in = (pins.data_out & pins.data_oe) | (tgt_data & ~pins.data_oe);

   fpp_port dut_u (.clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .done(done), .refused(refused), .busy(busy), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data), .gpio(gpio), .interface_clk_out(interface_clk_out), .pins(pins),
      .port_data_bus_in(bus_in));

   fpp_target_model tgt_u (.interface_clk_out(interface_clk_out), .pins(pins),
      .tgt_data(tgt_data), .bad(bad));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic give_up(input string what);
      $display("wrong value %s expected event seen timeout", what);
      fails++;
      summarize();
   endtask

   function automatic fpp_pkg::fpp_req_t mk(input logic rd, dt, wd, ae,
                                             input logic [9:0] len, input logic [8:0] st);
      mk = '{read_dir: rd, is_data: dt, wide: wd, addr_en: ae, len_bytes: len, start_addr: st};
   endfunction

   task automatic send_req(input fpp_pkg::fpp_req_t r);
      int n;
      n = 0;
      req <= r;
      req_valid <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (req_ready !== 1'b1 && n < 100);
      if (n >= 100) give_up("req_ready");
      req_valid <= 1'b0;
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (done !== 1'b1 && n < 3000);
      if (n >= 3000) give_up("done");
      check("busy_at_done", busy, 0);
   endtask

   task automatic push_words(input int cnt, input logic [15:0] base);
      int n;
      for (int i = 0; i < cnt; i++) begin
         wr_valid <= 1'b1;
         wr_data <= base + 16'(i);
         n = 0;
         do begin
            @(posedge clock);
            n++;
         end while (wr_ready !== 1'b1 && n < 3000);
         if (n >= 3000) give_up("wr_ready");
      end
      wr_valid <= 1'b0;
   endtask

   task automatic write_pkt(input logic dt, wd, ae, pre, input logic [9:0] len,
                            input logic [8:0] st, input logic [15:0] base);
      int el;
      logic [15:0] msk;
      el = wd ? len / 2 : len;
      msk = wd ? 16'hFFFF : 16'h00FF;
      tgt_u.wr_log.delete();
      if (pre) begin
         push_words(el, base);
         @(posedge clock);
         check("fifo_full", wr_ready, 0);
         send_req(mk(1'b0, dt, wd, ae, len, st));
      end else begin
         fork
            push_words(el, base);
            send_req(mk(1'b0, dt, wd, ae, len, st));
         join
      end
      wait_done();
      check("write_count", tgt_u.wr_log.size(), el);
      foreach (tgt_u.wr_log[i]) begin
         check("wr_data", tgt_u.wr_log[i][15:0] & msk, (base + 16'(i)) & msk);
         check("cmd_sel", tgt_u.wr_log[i][25], dt);
         check("addr_valid", tgt_u.wr_log[i][26], ae);
         if (ae) check("wr_addr", tgt_u.wr_log[i][24:16], 9'(st + 9'(i)));
      end
   endtask

   task automatic read_pkt(input logic wd, input logic [9:0] len, input logic [8:0] st,
                           input int stall);
      int el, n;
      logic [15:0] msk;
      logic [8:0] a;
      el = wd ? len / 2 : len;
      msk = wd ? 16'hFFFF : 16'h00FF;
      tgt_u.rd_log.delete();
      fork
         begin
            send_req(mk(1'b1, 1'b1, wd, 1'b1, len, st));
            repeat (stall) @(posedge clock);
            rd_ready <= 1'b1;
            for (int i = 0; i < el; i++) begin
               n = 0;
               do begin
                  @(posedge clock);
                  n++;
               end while (rd_valid !== 1'b1 && n < 3000);
               if (n >= 3000) give_up("rd_valid");
               a = st + 9'(i);
               check("rd_data", rd_data & msk, {a[7:0] ^ 8'hA5, a[7:0]} & msk);
            end
            rd_ready <= 1'b0;
         end
         wait_done();
      join
      check("read_count", tgt_u.rd_log.size(), el);
   endtask

   task automatic refusals();
      fpp_pkg::fpp_req_t r [3];
      r[0] = mk(1'b0, 1'b1, 1'b0, 1'b1, 10'h000, 9'h000);
      r[1] = mk(1'b0, 1'b1, 1'b0, 1'b1, 10'h201, 9'h000);
      r[2] = mk(1'b0, 1'b1, 1'b1, 1'b1, 10'h003, 9'h000);
      foreach (r[i]) begin
         send_req(r[i]);
         @(posedge clock);
         check("refused", refused, 1);
         check("busy_refused", busy, 0);
         @(posedge clock);
         check("refused_once", refused, 0);
      end
   endtask

   // Idle lanes must follow the general ports, which the transfer borrows only while busy.
   task automatic gpio_idle(input logic [7:0] v);
      gpio <= '{b_out: v, b_oe: ~v, c_out: v ^ 8'h3C, c_oe: ~v, d_out: ~v, d_oe: v,
                spi_slave_select_1: v[0]};
      repeat (3) @(posedge clock);
      check("data_out", pins.data_out, {~v, v});
      check("data_oe", pins.data_oe, {v, ~v});
      check("addr_out", pins.addr_out, {v[0], v ^ 8'h3C});
      check("addr_oe", pins.addr_oe, {1'b1, ~v});
   endtask

   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      wr_valid = 1'b0;
      wr_data = 16'h0000;
      rd_ready = 1'b0;
      gpio = '0;
      fails = 0;
      checked = 0;
      repeat (5) @(posedge clock);
      check("pins_reset", pins, fpp_pkg::PINS_RESET);
      check("ctl_reset", {interface_clk_out, req_ready, busy, done, refused}, 5'h08);
      check("stream_reset", {wr_ready, rd_valid}, 2'h2);
      rst <= 1'b0;
      gpio_idle(8'h5A);
      write_pkt(1'b0, 1'b0, 1'b1, 1'b1, 10'h020, 9'h1F0, 16'h1200);
      write_pkt(1'b1, 1'b1, 1'b0, 1'b0, 10'h008, 9'h000, 16'hBEEF);
      write_pkt(1'b1, 1'b0, 1'b1, 1'b0, 10'h200, 9'h100, 16'h0000);
      refusals();
      read_pkt(1'b0, 10'h040, 9'h1E0, 150);
      read_pkt(1'b1, 10'h006, 9'h005, 0);
      gpio_idle(8'hC3);
      check("strobe_polarity", bad, 0);
      summarize();
   end
endmodule // usb_module_fast_parallel_port_tb
